// [hw/uip_irq_dma.sv]
// Interrupt prioritisation, clearing and DMA request control for one UART channel.
////////////////////////////////////////////////////////////////////////////////
//
// Local design decision: the strobed register port.

// Function
// - Line status errors rank first, receive timeout second, data available third.
// - Transmit empty ranks fourth, modem change fifth; none pending reads 000001.
// - Xoff or special character ranks sixth; CTS/RTS rising edge ranks seventh.
// - Line interrupt raised by break, framing, parity, overrun; line status read clears.
// - Receive trigger interrupt holds until the count falls below trigger level.
// - Receive timeout after four characters plus twelve bits; buffer read clears.
// - Transmit empty interrupt cleared by identification read or holding write.
// - Modem interrupt when any low modem status bit rises from 0 to 1; modem status read clears.
// - Xoff interrupt clears on identification read, Xon, or next char if special.
// - Auto flow CTS or RTS rising edge interrupts; identification or modem read clears.
// - Offset 2 writes FIFO control and reads interrupt identification.
// - Mode 0 receive request low while any received character is held.
// - Mode 0 transmit request low while transmit FIFO or holding is empty.
// - Mode 1 receive request low at trigger count or timeout, high when empty.
// - Mode 1 transmit request low when FIFO empty, high only when full.
// - Data available interrupt at trigger level when its enable bit is set.
// - FIFO control bits 7:6 select trigger 1, 4, 8 or 14.
// - Identification indication freezes during its read; new events still recorded.
// - Burst DMA mode only with FIFOs enabled; mode 0 is the default.
module uip_irq_dma #(
  parameter int CHAR_BITS = 10,
  parameter int TX_DEPTH  = 16
) (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic [2:0]                addr,
  input  wire logic [7:0]                wrData,
  input  wire logic                      wrEn,
  input  wire logic                      rdEn,
  output logic      [7:0]                rdData,
  input  wire logic [7:0]                receiveData,
  input  wire logic [7:0]                lineStatus,
  input  wire logic [7:0]                modemStatus,
  input  wire logic [uip_pkg::CNT_W-1:0] rxCount,
  input  wire logic [uip_pkg::CNT_W-1:0] txCount,
  input  wire logic                      rxPush,
  input  wire logic                      bitTick,
  input  wire logic                      xoffSeen,
  input  wire logic                      specialSeen,
  input  wire logic                      xonSeen,
  input  wire logic                      ctsIn,
  input  wire logic                      rtsOut,
  input  wire logic                      autoCts,
  input  wire logic                      autoRts,
  output logic                           irqActive,
  output logic                           receiveRead,
  output logic                           transmitWrite,
  output logic      [7:0]                transmitData,
  output logic                           rxFifoClear,
  output logic                           txFifoClear,
  output logic                           fifoEnable,
  output logic                           rxDmaReq_b,
  output logic                           txDmaReq_b
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [7:0] interruptEnable;
  logic [7:0] fifoControl;
  logic [5:0] iirCode;
  logic [3:0] prevLineErr;
  logic [3:0] prevModem;
  logic       prevTxEmpty;
  logic       prevCts;
  logic       prevRts;
  logic       lineFlag;
  logic       threFlag;
  logic       modemFlag;
  logic       xoffFlag;
  logic       xoffBySpecial;
  logic       flowFlag;

  uip_fifo_if fifo ();

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  wire selRxBuf = (addr == uip_pkg::OFS_RX_BUF);
  wire selIer   = (addr == uip_pkg::OFS_IER);
  wire selIir   = (addr == uip_pkg::OFS_IIR_FCR);
  wire selLsr   = (addr == uip_pkg::OFS_LSR);
  wire selMsr   = (addr == uip_pkg::OFS_MSR);

  wire rdRxBuf  = rdEn & selRxBuf;
  wire rdIir    = rdEn & selIir;
  wire rdLsr    = rdEn & selLsr;
  wire rdMsr    = rdEn & selMsr;
  wire wrThr    = wrEn & selRxBuf;
  wire wrIer    = wrEn & selIer;
  wire wrFcr    = wrEn & selIir;

  logic [7:0] readMux;
  always_comb begin
    if (selRxBuf) begin
      readMux = receiveData;
    end else if (selIer) begin
      readMux = interruptEnable;
    end else if (selIir) begin
      readMux = {fifoControl[uip_pkg::FCR_FIFO_EN], fifoControl[uip_pkg::FCR_FIFO_EN],
                 iirCode};
    end else if (selLsr) begin
      readMux = lineStatus;
    end else if (selMsr) begin
      readMux = modemStatus;
    end else begin
      readMux = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // FIFO configuration.

  wire fifoOn = fifoControl[uip_pkg::FCR_FIFO_EN];
  wire [1:0] trigSel = fifoControl[uip_pkg::FCR_TRIG_HI:uip_pkg::FCR_TRIG_LO];

  logic [uip_pkg::CNT_W-1:0] trigLevel;
  always_comb begin
    case (trigSel)
      2'h0:    trigLevel = uip_pkg::TRIG_1;
      2'h1:    trigLevel = uip_pkg::TRIG_4;
      2'h2:    trigLevel = uip_pkg::TRIG_8;
      default: trigLevel = uip_pkg::TRIG_14;
    endcase
  end

  assign fifo.rxCount   = rxCount;
  assign fifo.txCount   = txCount;
  assign fifo.trigLevel = fifoOn ? trigLevel : uip_pkg::TRIG_1;
  assign fifo.fifoEn    = fifoOn;
  assign fifo.dmaMode1  = fifoControl[uip_pkg::FCR_DMA_MODE];
  assign fifo.rxPush    = rxPush;
  assign fifo.rxPop     = rdRxBuf;

  ////////////////////////////////////////////////////////////////////////////////
  // Event detection. Line, modem, transmit empty and flow sources are edge-detected so that a read can clear them.

  wire [3:0] lineErr  = lineStatus[4:1];
  wire       lineNew  = |(lineErr & ~prevLineErr);
  wire       modemNew = |(modemStatus[3:0] & ~prevModem);
  wire       txEmpty  = (txCount == '0);
  wire       threNew  = txEmpty & ~prevTxEmpty;
  wire       ctsRise  = autoCts & ctsIn & ~prevCts & interruptEnable[uip_pkg::IER_CTS];
  wire       rtsRise  = autoRts & rtsOut & ~prevRts & interruptEnable[uip_pkg::IER_RTS];
  wire       flowNew  = ctsRise | rtsRise;
  wire       xoffNew  = (xoffSeen | specialSeen) & interruptEnable[uip_pkg::IER_XOFF];

  wire rxLevelHit = fifoOn ? (rxCount >= trigLevel) : (rxCount != '0);

  ////////////////////////////////////////////////////////////////////////////////
  // Priority encoder.

  wire enRx = interruptEnable[uip_pkg::IER_RXDATA];

  logic [5:0] nextCode;
  always_comb begin
    if (lineFlag && interruptEnable[uip_pkg::IER_LINE]) begin
      nextCode = uip_pkg::IIR_LINE;
    end else if (fifo.timeoutHit && enRx) begin
      nextCode = uip_pkg::IIR_TIMEOUT;
    end else if (rxLevelHit && enRx) begin
      nextCode = uip_pkg::IIR_RXDATA;
    end else if (threFlag && interruptEnable[uip_pkg::IER_THRE]) begin
      nextCode = uip_pkg::IIR_THRE;
    end else if (modemFlag && interruptEnable[uip_pkg::IER_MODEM]) begin
      nextCode = uip_pkg::IIR_MODEM;
    end else if (xoffFlag) begin
      nextCode = uip_pkg::IIR_XOFF;
    end else if (flowFlag) begin
      nextCode = uip_pkg::IIR_FLOW;
    end else begin
      nextCode = uip_pkg::IIR_NONE;
    end
  end

  // An identification read clears transmit empty only when it reported it; the xoff and flow flags clear on any identification read.
  wire iirClrThre = rdIir & (iirCode == uip_pkg::IIR_THRE);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus registers and read data.

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      interruptEnable <= uip_pkg::IER_RESET;
      fifoControl     <= uip_pkg::FCR_RESET;
    end else begin
      if (wrIer) begin
        interruptEnable <= wrData;
      end
      if (wrFcr) begin
        fifoControl <= wrData;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData        <= 8'h00;
      receiveRead   <= 1'b0;
      transmitWrite <= 1'b0;
      transmitData  <= 8'h00;
      rxFifoClear   <= 1'b0;
      txFifoClear   <= 1'b0;
    end else begin
      rdData        <= rdEn ? readMux : 8'h00;
      receiveRead   <= rdRxBuf;
      transmitWrite <= wrThr;
      transmitData  <= wrThr ? wrData : transmitData;
      rxFifoClear   <= wrFcr & wrData[uip_pkg::FCR_RX_CLEAR] & wrData[uip_pkg::FCR_FIFO_EN];
      txFifoClear   <= wrFcr & wrData[uip_pkg::FCR_TX_CLEAR] & wrData[uip_pkg::FCR_FIFO_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky sources. An event in the same cycle as its clear always wins.

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prevLineErr <= 4'h0;
      prevModem   <= 4'h0;
      prevTxEmpty <= 1'b0;
      prevCts     <= 1'b0;
      prevRts     <= 1'b0;
    end else begin
      prevLineErr <= lineErr;
      prevModem   <= modemStatus[3:0];
      prevTxEmpty <= txEmpty;
      prevCts     <= ctsIn;
      prevRts     <= rtsOut;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lineFlag  <= 1'b0;
      threFlag  <= 1'b0;
      modemFlag <= 1'b0;
      flowFlag  <= 1'b0;
    end else begin
      lineFlag  <= lineNew | (lineFlag & ~rdLsr);
      threFlag  <= threNew | (threFlag & ~iirClrThre & ~wrThr);
      modemFlag <= modemNew | (modemFlag & ~rdMsr);
      flowFlag  <= flowNew | (flowFlag & ~rdIir & ~rdMsr);
    end
  end

  // A special character flag also falls on the following received character.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xoffFlag      <= 1'b0;
      xoffBySpecial <= 1'b0;
    end else if (xoffNew) begin
      xoffFlag      <= 1'b1;
      xoffBySpecial <= specialSeen & ~xoffSeen;
    end else if (rdIir || xonSeen || (xoffBySpecial && rxPush)) begin
      xoffFlag      <= 1'b0;
      xoffBySpecial <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Indication register, held still while the host reads it.

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      iirCode    <= uip_pkg::IIR_NONE;
      irqActive  <= 1'b0;
      fifoEnable <= 1'b0;
    end else begin
      if (!rdIir) begin
        iirCode   <= nextCode;
        irqActive <= (nextCode != uip_pkg::IIR_NONE);
      end
      fifoEnable <= fifoOn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timeout counter and DMA request pins.

  uip_rx_timeout #(
    .CHAR_BITS (CHAR_BITS)
  ) uTimeout (
    .clk     (clk),
    .rst_b   (rst_b),
    .bitTick (bitTick),
    .fifo    (fifo.tmo)
  );

  uip_dma_req #(
    .TX_DEPTH (TX_DEPTH)
  ) uDma (
    .clk        (clk),
    .rst_b      (rst_b),
    .fifo       (fifo.dma),
    .rxDmaReq_b (rxDmaReq_b),
    .txDmaReq_b (txDmaReq_b)
  );

endmodule : uip_irq_dma

// [hw/uip_pkg.sv]
// Constants shared by the interrupt priority and DMA request block.
package uip_pkg;

  // Register offsets on the three-bit register port.
  localparam logic [2:0] OFS_RX_BUF   = 3'h0;
  localparam logic [2:0] OFS_IER      = 3'h1;
  localparam logic [2:0] OFS_IIR_FCR  = 3'h2;
  localparam logic [2:0] OFS_LSR      = 3'h5;
  localparam logic [2:0] OFS_MSR      = 3'h6;

  // Interrupt identification codes, bits 5:0.
  localparam logic [5:0] IIR_LINE     = 6'h06;
  localparam logic [5:0] IIR_TIMEOUT  = 6'h0C;
  localparam logic [5:0] IIR_RXDATA   = 6'h04;
  localparam logic [5:0] IIR_THRE     = 6'h02;
  localparam logic [5:0] IIR_MODEM    = 6'h00;
  localparam logic [5:0] IIR_XOFF     = 6'h10;
  localparam logic [5:0] IIR_FLOW     = 6'h20;
  localparam logic [5:0] IIR_NONE     = 6'h01;

  // Interrupt enable bit positions.
  localparam int IER_RXDATA = 0;
  localparam int IER_THRE   = 1;
  localparam int IER_LINE   = 2;
  localparam int IER_MODEM  = 3;
  localparam int IER_XOFF   = 5;
  localparam int IER_RTS    = 6;
  localparam int IER_CTS    = 7;
  localparam logic [7:0] IER_RESET = 8'h00;

  // FIFO control bit positions.
  localparam int FCR_FIFO_EN  = 0;
  localparam int FCR_RX_CLEAR = 1;
  localparam int FCR_TX_CLEAR = 2;
  localparam int FCR_DMA_MODE = 3;
  localparam int FCR_TRIG_LO  = 6;
  localparam int FCR_TRIG_HI  = 7;
  localparam logic [7:0] FCR_RESET = 8'h00;

  // FIFO count width and receive trigger levels.
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] TRIG_1  = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_4  = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_8  = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_14 = 5'h0E;

  // Receive timeout: character times plus extra bit times.
  localparam int TMO_CHARS      = 4;
  localparam int TMO_EXTRA_BITS = 12;
  localparam int TMO_W          = 8;

endpackage : uip_pkg

// [hw/uip_fifo_if.sv]
// Interface carrying FIFO status and configuration between the block's modules.
interface uip_fifo_if;
  logic [uip_pkg::CNT_W-1:0] rxCount;
  logic [uip_pkg::CNT_W-1:0] txCount;
  logic [uip_pkg::CNT_W-1:0] trigLevel;
  logic                      fifoEn;
  logic                      dmaMode1;
  logic                      rxPush;
  logic                      rxPop;
  logic                      timeoutHit;

  modport ctrl (output rxCount, output txCount, output trigLevel, output fifoEn,
                output dmaMode1, output rxPush, output rxPop, input timeoutHit);
  modport tmo  (input rxCount, input fifoEn, input rxPush, input rxPop,
                output timeoutHit);
  modport dma  (input rxCount, input txCount, input trigLevel, input fifoEn,
                input dmaMode1, input timeoutHit);
endinterface : uip_fifo_if

// [hw/uip_rx_timeout.sv]
// Receive timeout counter measured in bit-time enable pulses.
module uip_rx_timeout #(
  parameter int CHAR_BITS = 10
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic bitTick,
  uip_fifo_if.tmo   fifo
);

  localparam int LIMIT_I = uip_pkg::TMO_CHARS * CHAR_BITS + uip_pkg::TMO_EXTRA_BITS;
  localparam logic [uip_pkg::TMO_W-1:0] LIMIT = uip_pkg::TMO_W'(LIMIT_I);

  logic [uip_pkg::TMO_W-1:0] bitCount;
  logic                      hit;

  wire restart  = fifo.rxPush | fifo.rxPop;
  wire counting = fifo.fifoEn & (fifo.rxCount != '0) & (bitCount != LIMIT);
  wire reached  = counting & bitTick & (bitCount == LIMIT - 1'b1);

  assign fifo.timeoutHit = hit;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCount <= '0;
    end else if (restart || !fifo.fifoEn || fifo.rxCount == '0) begin
      bitCount <= '0;
    end else if (counting && bitTick) begin
      bitCount <= bitCount + 1'b1;
    end
  end

  // A read of the receive buffer clears the flag, but a hit in that cycle wins.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit <= 1'b0;
    end else if (reached) begin
      hit <= 1'b1;
    end else if (fifo.rxPop || !fifo.fifoEn) begin
      hit <= 1'b0;
    end
  end

endmodule : uip_rx_timeout

// [hw/uip_dma_req.sv]
// Receive and transmit DMA request pins, active low, in modes 0 and 1.
module uip_dma_req #(
  parameter int TX_DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic rst_b,
  uip_fifo_if.dma   fifo,
  output logic      rxDmaReq_b,
  output logic      txDmaReq_b
);

  localparam logic [uip_pkg::CNT_W-1:0] TX_FULL = uip_pkg::CNT_W'(TX_DEPTH);

  // Burst mode is only honoured with FIFOs on; otherwise single transfers.
  wire burst   = fifo.dmaMode1 & fifo.fifoEn;
  wire rxEmpty = (fifo.rxCount == '0);
  wire txEmpty = (fifo.txCount == '0);
  wire rxStart = (fifo.rxCount == fifo.trigLevel) | fifo.timeoutHit;
  wire txFull  = (fifo.txCount == TX_FULL);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxDmaReq_b <= 1'b1;
    end else if (!burst) begin
      rxDmaReq_b <= rxEmpty;
    end else if (rxEmpty) begin
      rxDmaReq_b <= 1'b1;
    end else if (rxStart) begin
      rxDmaReq_b <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txDmaReq_b <= 1'b0;
    end else if (!burst) begin
      txDmaReq_b <= ~txEmpty;
    end else if (txEmpty) begin
      txDmaReq_b <= 1'b0;
    end else if (txFull) begin
      txDmaReq_b <= 1'b1;
    end
  end

endmodule : uip_dma_req

// [tb/uip_irq_dma_props.sv]
// Port-level assertions for the interrupt priority and DMA request block.
module uip_irq_dma_props #(
  parameter int TX_DEPTH = 16
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [2:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrEn,
  input wire logic       rdEn,
  input wire logic [7:0] rdData,
  input wire logic [4:0] rxCount,
  input wire logic [4:0] txCount,
  input wire logic       receiveRead,
  input wire logic       transmitWrite,
  input wire logic [7:0] transmitData,
  input wire logic       fifoEnable,
  input wire logic       rxDmaReq_b,
  input wire logic       txDmaReq_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////
  // Single transfer mode is only certain while no control write could switch it.
  wire modeZero = !fifoEnable && !(wrEn && addr == 3'h2);

  a_idle_read_zero: assert property (
    !rdEn |=> rdData == 8'h00) else $error("read data not zero while idle");
  // The enable pin lags the control register by one cycle, just as the read data does.
  a_ident_fifo_bits: assert property (
    rdEn && addr == 3'h2 |=> rdData[7:6] == {2{fifoEnable}})
    else $error("identification fifo bits wrong");
  a_buffer_read_pop: assert property (
    rdEn && addr == 3'h0 |=> receiveRead) else $error("buffer read did not pop");
  a_holding_write_pass: assert property (
    wrEn && addr == 3'h0 |=> transmitWrite && transmitData == $past(wrData))
    else $error("holding write not passed on");
  a_control_enable_bit: assert property (
    wrEn && addr == 3'h2 |-> ##2 fifoEnable == $past(wrData[0], 2))
    else $error("fifo enable wrong");
  a_rx_req_mode0: assert property (
    modeZero && !$past(wrEn && addr == 3'h2) && rxCount != 5'h00 |=> !rxDmaReq_b)
    else $error("rx request not low");
  a_rx_req_empty: assert property (
    rxCount == 5'h00 |=> rxDmaReq_b) else $error("rx request not high when empty");
  a_tx_req_empty: assert property (
    txCount == 5'h00 |=> !txDmaReq_b) else $error("tx request not low when empty");
  a_tx_req_full: assert property (
    txCount == 5'(TX_DEPTH) |=> txDmaReq_b) else $error("tx request not high when full");
endmodule : uip_irq_dma_props

bind uip_irq_dma uip_irq_dma_props #(.TX_DEPTH(TX_DEPTH)) u_props (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
  .rdData(rdData), .rxCount(rxCount), .txCount(txCount), .receiveRead(receiveRead),
  .transmitWrite(transmitWrite), .transmitData(transmitData), .fifoEnable(fifoEnable),
  .rxDmaReq_b(rxDmaReq_b), .txDmaReq_b(txDmaReq_b)
);

// [tb/uip_fifo_model.sv]
// Channel data path stand-in that tracks receive and transmit FIFO fill levels.
module uip_fifo_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       pushReq,
  input  wire logic       takeReq,
  input  wire logic       receiveRead,
  input  wire logic       transmitWrite,
  input  wire logic       rxFifoClear,
  input  wire logic       txFifoClear,
  output wire logic       rxPush,
  output logic      [4:0] rxCount,
  output logic      [4:0] txCount
);
  timeunit 1ns;
  timeprecision 1ns;
  assign rxPush = pushReq;
  // No overflow guard: the bench never overfills, so a wrap shows as a wrong request level.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxCount <= 5'h00;
      txCount <= 5'h00;
    end else begin
      rxCount <= rxFifoClear ? 5'h00 : rxCount + 5'(pushReq) - 5'(receiveRead);
      txCount <= txFifoClear ? 5'h00 : txCount + 5'(transmitWrite) - 5'(takeReq);
    end
  end
endmodule : uip_fifo_model

// [tb/test_uip_irq_dma.sv]
// Self-checking bench for the interrupt priority and DMA request block.
module test_uip_irq_dma;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk         = 1'b0;
  logic       rst_b       = 1'b0;
  logic [2:0] addr        = 3'h0;
  logic [7:0] wrData      = 8'h00;
  logic       wrEn        = 1'b0;
  logic       rdEn        = 1'b0;
  logic [7:0] lineStatus  = 8'h00;
  logic [7:0] modemStatus = 8'h00;
  logic       bitTick     = 1'b0;
  logic       ctsIn       = 1'b0;
  logic       rtsOut      = 1'b0;
  logic       autoCts     = 1'b0;
  logic       autoRts     = 1'b0;
  logic [4:0] ev          = 5'h00;
  logic [4:0] trg [4]     = '{5'h01, 5'h04, 5'h08, 5'h0E};
  int         n_fail      = 0;
  int         n_checks    = 0;
  wire  [7:0] rdData;
  wire  [4:0] rxCount, txCount;
  wire        rxPush, receiveRead, transmitWrite, rxFifoClear, txFifoClear;
  wire        rxDmaReq_b, txDmaReq_b, irqActive;

  always #50 clk = ~clk;
  always @(posedge clk) bitTick <= ~bitTick;

  uip_irq_dma uut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData(rdData), .receiveData(8'h5A), .lineStatus(lineStatus),
    .modemStatus(modemStatus), .rxCount(rxCount), .txCount(txCount), .rxPush(rxPush),
    .bitTick(bitTick), .xoffSeen(ev[0]), .specialSeen(ev[1]), .xonSeen(ev[2]),
    .ctsIn(ctsIn), .rtsOut(rtsOut), .autoCts(autoCts), .autoRts(autoRts),
    .irqActive(irqActive), .receiveRead(receiveRead), .transmitWrite(transmitWrite),
    .transmitData(), .rxFifoClear(rxFifoClear), .txFifoClear(txFifoClear),
    .fifoEnable(), .rxDmaReq_b(rxDmaReq_b), .txDmaReq_b(txDmaReq_b)
  );
  uip_fifo_model far (
    .clk(clk), .rst_b(rst_b), .pushReq(ev[3]), .takeReq(ev[4]), .receiveRead(receiveRead),
    .transmitWrite(transmitWrite), .rxFifoClear(rxFifoClear), .txFifoClear(txFifoClear),
    .rxPush(rxPush), .rxCount(rxCount), .txCount(txCount)
  );
  ////////////////////////////////////////////////
  task summarize();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t pin %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask : wr

  task rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    chk8(rdData, exp);
  endtask : rd

  // Event bits: 0 xoff, 1 special, 2 xon, 3 receive push, 4 transmit take.
  task pl(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev <= 5'h00;
  endtask : pl

  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd(3'h2, 8'h01);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    chk1(txDmaReq_b, 1'b0);
    chk1(rxDmaReq_b, 1'b1);
    wr(3'h1, 8'h02);
    rd(3'h2, 8'h02);
    rd(3'h2, 8'h01);
    wr(3'h0, 8'h3C);
    wt(3);
    chk1(txDmaReq_b, 1'b1);
    pl(4);
    wt(3);
    chk1(txDmaReq_b, 1'b0);
    wr(3'h0, 8'h3C);
    rd(3'h2, 8'h01);
    pl(4);
    wr(3'h1, 8'h0F);
    @(posedge clk);
    lineStatus  <= 8'h02;
    modemStatus <= 8'h01;
    pl(3);
    wt(3);
    chk1(rxDmaReq_b, 1'b0);
    rd(3'h2, 8'h06);
    chk1(irqActive, 1'b1);
    rd(3'h5, 8'h02);
    rd(3'h2, 8'h04);
    rd(3'h0, 8'h5A);
    wt(3);
    chk1(rxDmaReq_b, 1'b1);
    rd(3'h2, 8'h02);
    rd(3'h2, 8'h00);
    rd(3'h6, 8'h01);
    rd(3'h2, 8'h01);
    chk1(irqActive, 1'b0);
    @(posedge clk);
    lineStatus  <= 8'h00;
    modemStatus <= 8'h00;
    wr(3'h1, 8'hE0);
    pl(0);
    wt(2);
    rd(3'h2, 8'h10);
    rd(3'h2, 8'h01);
    pl(0);
    pl(2);
    wt(2);
    rd(3'h2, 8'h01);
    pl(1);
    pl(3);
    wt(2);
    rd(3'h2, 8'h01);
    rd(3'h0, 8'h5A);
    @(posedge clk);
    autoCts <= 1'b1;
    ctsIn   <= 1'b1;
    wt(2);
    rd(3'h2, 8'h20);
    rd(3'h6, 8'h00);
    rd(3'h2, 8'h01);
    @(posedge clk);
    autoRts <= 1'b1;
    rtsOut  <= 1'b1;
    wt(2);
    rd(3'h2, 8'h20);
    rd(3'h2, 8'h01);
    wr(3'h1, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(3'h2, {2'(i), 6'h01});
      repeat (trg[i] - 1) pl(3);
      wt(2);
      rd(3'h2, 8'hC1);
      pl(3);
      wt(2);
      rd(3'h2, 8'hC4);
      rd(3'h0, 8'h5A);
      wt(2);
      rd(3'h2, 8'hC1);
      wr(3'h2, {2'(i), 6'h03});
    end
    pl(3);
    wt(3);
    chk1(rxDmaReq_b, 1'b0);
    wt(40);
    rd(3'h2, 8'hC1);
    wt(80);
    rd(3'h2, 8'hCC);
    rd(3'h0, 8'h5A);
    wt(2);
    rd(3'h2, 8'hC1);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h49);
    repeat (3) pl(3);
    wt(2);
    chk1(rxDmaReq_b, 1'b1);
    pl(3);
    wt(2);
    chk1(rxDmaReq_b, 1'b0);
    rd(3'h0, 8'h5A);
    wt(2);
    chk1(rxDmaReq_b, 1'b0);
    repeat (3) rd(3'h0, 8'h5A);
    wt(2);
    chk1(rxDmaReq_b, 1'b1);
    wr(3'h0, 8'h11);
    wt(2);
    chk1(txDmaReq_b, 1'b0);
    repeat (15) wr(3'h0, 8'h11);
    wt(2);
    chk1(txDmaReq_b, 1'b1);
    pl(4);
    wt(2);
    chk1(txDmaReq_b, 1'b1);
    summarize();
  end
endmodule : test_uip_irq_dma
